// *** dtcfg_pkg.sv ***
// Package for the data-training configuration register bank.
// Assumes an APB master in the controller register clock domain.
package dtcfg_pkg;

    localparam logic [11:0] DTCFG_SETUP_OFFSET = 12'h000;
    localparam logic [11:0] DTCFG_STEP_STAT_OFFSET = 12'h004;

    // Field positions in the setup register
    localparam int DTCFG_RFSH_LSB = 28;
    localparam int DTCFG_RANK_LSB = 24;
    localparam int DTCFG_EXTD_BIT = 22;
    localparam int DTCFG_STEP_BIT = 21;
    localparam int DTCFG_DBGEN_BIT = 20;
    localparam int DTCFG_LANE_LSB = 16;
    localparam int DTCFG_CENT_BIT = 13;
    localparam int DTCFG_MASK_BIT = 12;
    localparam int DTCFG_MARGIN_LSB = 8;
    localparam int DTCFG_CMP_BIT = 7;
    localparam int DTCFG_MPR_BIT = 6;
    localparam int DTCFG_DRANK_LSB = 4;
    localparam int DTCFG_RPT_LSB = 0;

    // Reset values
    localparam logic [3:0] DTCFG_RFSH_RST = 4'h9;
    localparam logic [3:0] DTCFG_RANK_RST = 4'hf;
    localparam logic DTCFG_EXTD_RST = 1'b0;
    localparam logic DTCFG_DBGEN_RST = 1'b0;
    localparam logic [3:0] DTCFG_LANE_RST = 4'h0;
    localparam logic DTCFG_CENT_RST = 1'b1;
    localparam logic DTCFG_MASK_RST = 1'b1;
    localparam logic [3:0] DTCFG_MARGIN_RST = 4'h5;
    localparam logic DTCFG_CMP_RST = 1'b1;
    localparam logic DTCFG_MPR_RST = 1'b0;
    localparam logic [1:0] DTCFG_DRANK_RST = 2'h0;
    localparam logic [3:0] DTCFG_RPT_RST = 4'h7;

    typedef struct packed {
        logic [3:0] refresh_burst_count;
        logic [3:0] training_rank_mask;
        logic extended_strobe_postamble;
        logic debug_mode_on;
        logic [3:0] debug_lane_select;
        logic deskew_centering_on;
        logic mask_deskew_on;
        logic [3:0] write_strobe_margin;
        logic gate_compare_data;
        logic use_pattern_register;
        logic [1:0] deskew_rank_select;
        logic [3:0] stability_repeat_count;
    } dtcfg_fields_t;

    typedef enum logic [0:0] {
        DTCFG_IDLE = 1'b0,
        DTCFG_WAIT = 1'b1
    } dtcfg_step_t;

endpackage : dtcfg_pkg

// *** dtcfg_regs.sv ***
// Data-training configuration register bank with APB slave.
// Assumes the training engine acknowledges each single-step request.
//
// The register offsets and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
module dtcfg_regs
    import dtcfg_pkg::*;
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // APB slave
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [11:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // Training engine
    output dtcfg_fields_t cfg_out,
    output logic step_req_out,
    input wire logic step_ack_in,
    input wire logic [7:0] engine_state_in
);

    dtcfg_fields_t cfg_q;
    logic step_q;
    logic [31:0] prdata_q;
    logic slverr_q;
    logic [31:0] setup_word;
    logic wr_setup;
    logic access;
    logic mapped;
    logic step_write;
    dtcfg_step_t step_state_q;

    // Reset image of the fields, for the reset check
    localparam dtcfg_fields_t CFG_DEFAULTS = '{
        refresh_burst_count: DTCFG_RFSH_RST,
        training_rank_mask: DTCFG_RANK_RST,
        extended_strobe_postamble: DTCFG_EXTD_RST,
        debug_mode_on: DTCFG_DBGEN_RST,
        debug_lane_select: DTCFG_LANE_RST,
        deskew_centering_on: DTCFG_CENT_RST,
        mask_deskew_on: DTCFG_MASK_RST,
        write_strobe_margin: DTCFG_MARGIN_RST,
        gate_compare_data: DTCFG_CMP_RST,
        use_pattern_register: DTCFG_MPR_RST,
        deskew_rank_select: DTCFG_DRANK_RST,
        stability_repeat_count: DTCFG_RPT_RST
    };

    assign access = psel_in && penable_in;
    assign mapped = (paddr_in == DTCFG_SETUP_OFFSET) || (paddr_in == DTCFG_STEP_STAT_OFFSET);
    assign wr_setup = access && pwrite_in && (paddr_in == DTCFG_SETUP_OFFSET);
    assign step_write = wr_setup && pwdata_in[DTCFG_STEP_BIT];
    // Zero-wait slave
    assign pready_out = 1'b1;

    // Reserved bits 23, 15 and 14 are never stored
    always_comb
    begin
        setup_word = 32'h0000_0000;
        setup_word[DTCFG_RFSH_LSB +: 4] = cfg_q.refresh_burst_count;
        setup_word[DTCFG_RANK_LSB +: 4] = cfg_q.training_rank_mask;
        setup_word[DTCFG_EXTD_BIT] = cfg_q.extended_strobe_postamble;
        setup_word[DTCFG_STEP_BIT] = step_q;
        setup_word[DTCFG_DBGEN_BIT] = cfg_q.debug_mode_on;
        setup_word[DTCFG_LANE_LSB +: 4] = cfg_q.debug_lane_select;
        setup_word[DTCFG_CENT_BIT] = cfg_q.deskew_centering_on;
        setup_word[DTCFG_MASK_BIT] = cfg_q.mask_deskew_on;
        setup_word[DTCFG_MARGIN_LSB +: 4] = cfg_q.write_strobe_margin;
        setup_word[DTCFG_CMP_BIT] = cfg_q.gate_compare_data;
        setup_word[DTCFG_MPR_BIT] = cfg_q.use_pattern_register;
        setup_word[DTCFG_DRANK_LSB +: 2] = cfg_q.deskew_rank_select;
        setup_word[DTCFG_RPT_LSB +: 4] = cfg_q.stability_repeat_count;
    end

    // Configuration fields
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            cfg_q.refresh_burst_count <= DTCFG_RFSH_RST;
            cfg_q.training_rank_mask <= DTCFG_RANK_RST;
            cfg_q.extended_strobe_postamble <= DTCFG_EXTD_RST;
            cfg_q.debug_mode_on <= DTCFG_DBGEN_RST;
            cfg_q.debug_lane_select <= DTCFG_LANE_RST;
            cfg_q.deskew_centering_on <= DTCFG_CENT_RST;
            cfg_q.mask_deskew_on <= DTCFG_MASK_RST;
            cfg_q.write_strobe_margin <= DTCFG_MARGIN_RST;
            cfg_q.gate_compare_data <= DTCFG_CMP_RST;
            cfg_q.use_pattern_register <= DTCFG_MPR_RST;
            cfg_q.deskew_rank_select <= DTCFG_DRANK_RST;
            cfg_q.stability_repeat_count <= DTCFG_RPT_RST;
        end
        else if (wr_setup)
        begin
            cfg_q.refresh_burst_count <= pwdata_in[DTCFG_RFSH_LSB +: 4];
            cfg_q.training_rank_mask <= pwdata_in[DTCFG_RANK_LSB +: 4];
            cfg_q.extended_strobe_postamble <= pwdata_in[DTCFG_EXTD_BIT];
            cfg_q.debug_mode_on <= pwdata_in[DTCFG_DBGEN_BIT];
            cfg_q.debug_lane_select <= pwdata_in[DTCFG_LANE_LSB +: 4];
            cfg_q.deskew_centering_on <= pwdata_in[DTCFG_CENT_BIT];
            cfg_q.mask_deskew_on <= pwdata_in[DTCFG_MASK_BIT];
            cfg_q.write_strobe_margin <= pwdata_in[DTCFG_MARGIN_LSB +: 4];
            cfg_q.gate_compare_data <= pwdata_in[DTCFG_CMP_BIT];
            cfg_q.use_pattern_register <= pwdata_in[DTCFG_MPR_BIT];
            cfg_q.deskew_rank_select <= pwdata_in[DTCFG_DRANK_LSB +: 2];
            cfg_q.stability_repeat_count <= pwdata_in[DTCFG_RPT_LSB +: 4];
        end
    end

    assign cfg_out = cfg_q;

    // Single-step request: one request per written one, held until the engine acks.
    // A second write of one while waiting is ignored so the engine never double-steps.
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            step_q <= 1'b0;
            step_state_q <= DTCFG_IDLE;
        end
        else
        begin
            case (step_state_q)
                DTCFG_IDLE:
                begin
                    if (wr_setup && pwdata_in[DTCFG_STEP_BIT])
                    begin
                        step_q <= 1'b1;
                        step_state_q <= DTCFG_WAIT;
                    end
                end
                DTCFG_WAIT:
                begin
                    if (step_ack_in)
                    begin
                        step_q <= 1'b0;
                        step_state_q <= DTCFG_IDLE;
                    end
                end
                default:
                begin
                    step_q <= 1'b0;
                    step_state_q <= DTCFG_IDLE;
                end
            endcase
        end
    end

    assign step_req_out = step_q;

    // Read data and error answer
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            prdata_q <= 32'h0000_0000;
            slverr_q <= 1'b0;
        end
        else if (psel_in && !penable_in)
        begin
            slverr_q <= !mapped;
            if (!pwrite_in && paddr_in == DTCFG_SETUP_OFFSET)
            begin
                prdata_q <= setup_word;
            end
            else if (!pwrite_in && paddr_in == DTCFG_STEP_STAT_OFFSET)
            begin
                prdata_q <= {23'h000000, step_q, engine_state_in};
            end
            else
            begin
                prdata_q <= 32'h0000_0000;
            end
        end
    end

    // Answer only during the access phase
    assign prdata_out = access ? prdata_q : 32'h0000_0000;
    assign pslverr_out = access ? slverr_q : 1'b0;

    // Reserved bits never show as ones
    reserved_zero_a: assert property (@(posedge clk_in) disable iff (rst_in)
        setup_word[15:14] == 2'b00 && setup_word[23] == 1'b0)
        else $error("Reserved bits read nonzero");

    write_fields_a: assert property (@(posedge clk_in) disable iff (rst_in)
        wr_setup |=> cfg_q.training_rank_mask == $past(pwdata_in[27:24])
            && cfg_q.refresh_burst_count == $past(pwdata_in[31:28]))
        else $error("Rank mask or refresh count not stored");

    debug_mode_a: assert property (@(posedge clk_in) disable iff (rst_in)
        wr_setup |=> cfg_out.debug_mode_on == $past(pwdata_in[20])
            && cfg_out.debug_lane_select == $past(pwdata_in[19:16]))
        else $error("Debug mode or lane not stored");

    step_start_a: assert property (@(posedge clk_in) disable iff (rst_in)
        (!step_q && wr_setup && pwdata_in[21]) |=> step_req_out)
        else $error("Step request not raised");

    step_clear_a: assert property (@(posedge clk_in) disable iff (rst_in)
        (step_q && step_ack_in) |=> !step_req_out)
        else $error("Step request not cleared after ack");

    step_hold_a: assert property (@(posedge clk_in) disable iff (rst_in)
        (step_q && !step_ack_in) |=> step_req_out)
        else $error("Step request dropped before ack");

    step_quiet_a: assert property (@(posedge clk_in) disable iff (rst_in)
        (!step_q && !(wr_setup && pwdata_in[21])) |=> !step_req_out)
        else $error("Spurious step request");

    hold_fields_a: assert property (@(posedge clk_in) disable iff (rst_in)
        !wr_setup |=> $stable(cfg_q))
        else $error("Fields changed without write");

    margin_flags_a: assert property (@(posedge clk_in) disable iff (rst_in)
        wr_setup |=> cfg_out.write_strobe_margin == $past(pwdata_in[11:8])
            && cfg_out.gate_compare_data == $past(pwdata_in[7])
            && cfg_out.use_pattern_register == $past(pwdata_in[6]))
        else $error("Margin or gate flags not stored");

    // Further store properties, one field each except rank select with repeat count
    refresh_store_a: assert property (@(posedge clk_in) disable iff (rst_in)
        wr_setup
        |=> cfg_out.refresh_burst_count == $past(pwdata_in[31:28]))
        else $error("Refresh count not stored");

    extd_store_a: assert property (@(posedge clk_in) disable iff (rst_in)
        wr_setup
        |=> cfg_out.extended_strobe_postamble == $past(pwdata_in[22]))
        else $error("Extended strobe bit not stored");

    lane_store_a: assert property (@(posedge clk_in) disable iff (rst_in)
        wr_setup
        |=> cfg_out.debug_lane_select == $past(pwdata_in[19:16]))
        else $error("Lane select not stored");

    centering_store_a: assert property (@(posedge clk_in) disable iff (rst_in)
        wr_setup
        |=> cfg_out.deskew_centering_on == $past(pwdata_in[13]))
        else $error("Centering bit not stored");

    mask_store_a: assert property (@(posedge clk_in) disable iff (rst_in)
        wr_setup
        |=> cfg_out.mask_deskew_on == $past(pwdata_in[12]))
        else $error("Mask deskew bit not stored");

    gate_compare_a: assert property (@(posedge clk_in) disable iff (rst_in)
        wr_setup
        |=> cfg_out.gate_compare_data == $past(pwdata_in[7]))
        else $error("Compare bit not stored");

    pattern_store_a: assert property (@(posedge clk_in) disable iff (rst_in)
        wr_setup
        |=> cfg_out.use_pattern_register == $past(pwdata_in[6]))
        else $error("Pattern bit not stored");

    rank_repeat_a: assert property (@(posedge clk_in) disable iff (rst_in)
        wr_setup
        |=> cfg_out.deskew_rank_select == $past(pwdata_in[5:4])
            && cfg_out.stability_repeat_count == $past(pwdata_in[3:0]))
        else $error("Rank select or repeat count not stored");

    // Reset, read answers and refusals
    reset_fields_a: assert property (@(posedge clk_in)
        rst_in
        |=> cfg_q == CFG_DEFAULTS
            && !step_req_out)
        else $error("Defaults not loaded by reset");

    read_setup_a: assert property (@(posedge clk_in) disable iff (rst_in)
        (psel_in && !penable_in && !pwrite_in
            && paddr_in == DTCFG_SETUP_OFFSET)
        |=> prdata_q == $past(setup_word))
        else $error("Setup read data wrong");

    read_status_a: assert property (@(posedge clk_in) disable iff (rst_in)
        (psel_in && !penable_in && !pwrite_in
            && paddr_in == DTCFG_STEP_STAT_OFFSET)
        |=> prdata_q[8] == $past(step_q)
            && prdata_q[7:0] == $past(engine_state_in))
        else $error("Status read data wrong");

    unmapped_read_a: assert property (@(posedge clk_in) disable iff (rst_in)
        (psel_in && !penable_in && !pwrite_in
            && !mapped)
        |=> prdata_q == 32'h0000_0000)
        else $error("Unmapped read not zero");

    unmapped_err_a: assert property (@(posedge clk_in) disable iff (rst_in)
        (access && !mapped)
        |-> pslverr_out)
        else $error("Unmapped access not refused");

    mapped_ok_a: assert property (@(posedge clk_in) disable iff (rst_in)
        (access && mapped)
        |-> !pslverr_out)
        else $error("Mapped access refused");

    status_write_a: assert property (@(posedge clk_in) disable iff (rst_in)
        (access && pwrite_in
            && paddr_in == DTCFG_STEP_STAT_OFFSET)
        |=> $stable(cfg_q))
        else $error("Status write changed fields");

    step_single_a: assert property (@(posedge clk_in) disable iff (rst_in)
        $rose(step_req_out)
        |-> $past(step_write))
        else $error("Step request raised without a write");

    cover_write_c: cover property (@(posedge clk_in) disable iff (rst_in) wr_setup);
    cover_step_c: cover property (@(posedge clk_in) disable iff (rst_in)
        step_req_out ##[1:32] !step_req_out);
    cover_read_c: cover property (@(posedge clk_in) disable iff (rst_in)
        access && !pwrite_in && mapped);
    cover_err_c: cover property (@(posedge clk_in) disable iff (rst_in) access && !mapped);
    cover_refuse_c: cover property (@(posedge clk_in) disable iff (rst_in)
        step_q && step_write);

endmodule : dtcfg_regs

// *** test_data_training_config.sv ***
// Self-checking bench for the data-training configuration register bank.
// Assumes a zero-wait APB slave and a step request held until acknowledged.
`timescale 1ns/1ps
module test_data_training_config;
    import dtcfg_pkg::*;
    // Writable bits of the setup word; bit 21 reads the step request, which clears on the engine ack, so it is left out
    localparam logic [31:0] RW_MASK = 32'hff5f3fff;
    localparam logic [31:0] RST_WORD = 32'h9f003587;
    logic clk_in, rst_in, psel, penable, pwrite, step_ack, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, rd, v;
    logic [7:0] eng;
    logic [31:0] prdata_out;
    logic pready_out, pslverr_out, step_req_out;
    dtcfg_fields_t cfg_out;
    int error_cnt, checks;

    dtcfg_regs dut (.clk_in(clk_in), .rst_in(rst_in), .psel_in(psel), .penable_in(penable),
        .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata_out),
        .pready_out(pready_out), .pslverr_out(pslverr_out), .cfg_out(cfg_out),
        .step_req_out(step_req_out), .step_ack_in(step_ack), .engine_state_in(eng));

    initial
    begin
        clk_in = 1'b0;
        forever #12.5 clk_in = ~clk_in;
    end

    function automatic dtcfg_fields_t to_cfg(input logic [31:0] w);
        return {w[31:24], w[22], w[20:16], w[13:0]};
    endfunction : to_cfg

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic report_and_stop;
        $display("Checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : report_and_stop

    // Bounded wait on pready; a stuck slave is counted, not hung on
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_in);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_in);
        penable <= 1'b1;
        do
        begin
            @(posedge clk_in);
            n++;
        end
        while (pready_out !== 1'b1 && n < 50);
        if (n >= 50)
            chk("pready", 32'h1, 32'h0);
        rd = prdata_out;
        err = pslverr_out;
        psel <= 1'b0;
        penable <= 1'b0;
        eng <= 8'($urandom);
    endtask : apb

    task automatic reset_and_check;
        rst_in <= 1'b1;
        repeat (2) @(posedge clk_in);
        rst_in <= 1'b0;
        @(negedge clk_in);
        chk("cfg_reset", 32'(to_cfg(RST_WORD)), 32'(cfg_out));
        apb(1'b0, DTCFG_SETUP_OFFSET, 32'h0);
        chk("setup_reset", RST_WORD, rd);
    endtask : reset_and_check

    initial
    begin
        #(25 * 20000);
        error_cnt++;
        report_and_stop();
    end

    initial
    begin
        {rst_in, psel, penable, pwrite, step_ack, paddr, pwdata, eng} = '0;
        rst_in = 1'b1;
        error_cnt = 0;
        checks = 0;
        void'($urandom(32'ha22e2116));
        reset_and_check();
        // Corner words first, then random ones; bit 21 kept clear here
        for (int i = 0; i < 24; i++)
        begin
            v = (i == 0) ? 32'h0 : (i == 1) ? 32'hffdfffff : $urandom & 32'hffdfffff;
            apb(1'b1, DTCFG_SETUP_OFFSET, v);
            @(negedge clk_in);
            chk("cfg_out", 32'(to_cfg(v)), 32'(cfg_out));
            apb(1'b0, DTCFG_SETUP_OFFSET, 32'h0);
            chk("setup_read", v & RW_MASK, rd);
            chk("slverr_rd", 32'h0, 32'(err));
        end
        // Extended strobe added to the reset word, as software sets it for a read deskew pass
        apb(1'b1, DTCFG_SETUP_OFFSET, RST_WORD | 32'h00400000);
        @(negedge clk_in);
        chk("extd_on", 32'(to_cfg(RST_WORD | 32'h00400000)), 32'(cfg_out));
        // Single step: pending request ignores a second step write
        apb(1'b1, DTCFG_SETUP_OFFSET, v | 32'h00200000);
        @(negedge clk_in);
        chk("step_req", 32'h1, 32'(step_req_out));
        apb(1'b1, DTCFG_SETUP_OFFSET, v | 32'h00200000);
        chk("step_pending", 32'h1, 32'(step_req_out));
        apb(1'b0, DTCFG_SETUP_OFFSET, 32'h0);
        chk("setup_step", (v & RW_MASK) | 32'h00200000, rd);
        apb(1'b0, DTCFG_STEP_STAT_OFFSET, 32'h0);
        chk("status", {23'h0, 1'b1, eng}, rd);
        @(posedge clk_in);
        step_ack <= 1'b1;
        @(posedge clk_in);
        step_ack <= 1'b0;
        @(negedge clk_in);
        chk("step_clear", 32'h0, 32'(step_req_out));
        repeat (4) @(posedge clk_in);
        chk("one_step", 32'h0, 32'(step_req_out));
        apb(1'b0, DTCFG_SETUP_OFFSET, 32'h0);
        chk("setup_after", v & RW_MASK, rd);
        // Unmapped address: refused, data unchanged
        apb(1'b1, 12'h0f0, 32'h0);
        chk("slverr_wr", 32'h1, 32'(err));
        apb(1'b0, 12'h0f0, 32'h0);
        chk("unmapped_rd", 32'h0, rd);
        apb(1'b1, DTCFG_STEP_STAT_OFFSET, 32'hffffffff);
        chk("slverr_st", 32'h0, 32'(err));
        chk("cfg_kept", 32'(to_cfg(v)), 32'(cfg_out));
        // Reset in mid-run brings defaults back
        reset_and_check();
        report_and_stop();
    end
endmodule : test_data_training_config
